// File: hdl/synth_ctrl_pkg.sv
package synth_ctrl_pkg;

    // --------------------------------------------------------------------
    // Register offsets
    // --------------------------------------------------------------------
    localparam logic [7:0] FREQ_WORD_MSBS_ADDR = 8'h00;
    localparam logic [7:0] FREQ_WORD_BASE_ADDR = 8'h01;
    localparam logic [7:0] FREQ_WORD_LAST_ADDR = 8'h08;
    localparam logic [7:0] DEVIATION_SETTING_ADDR = 8'h09;
    localparam logic [7:0] AMPLITUDE_SETTING_0_ADDR = 8'h0a;
    localparam logic [7:0] AMPLITUDE_SETTING_1_ADDR = 8'h0b;
    localparam logic [7:0] AMPLITUDE_SETTING_2_ADDR = 8'h0c;
    localparam logic [7:0] RAMP_CONTROL_ADDR = 8'h0d;
    localparam logic [7:0] TRANSMITTER_CONTROL_ADDR = 8'h0e;

    // --------------------------------------------------------------------
    // Field positions and masks
    // --------------------------------------------------------------------
    localparam int SYNTH_RUN_BIT = 0;
    localparam int OSC_REGULATED_SUPPLY_BIT = 1;
    localparam int BAND_DIVIDER_SEL_BIT = 4;
    localparam int REF_HALVE_SEL_BIT = 5;
    localparam int AMPMOD_ON_BIT = 7;
    localparam int SUPPLY_FAIL_DETECT_EN_BIT = 5;
    localparam int REGULATOR_ADAPTIVE_EN_BIT = 6;
    localparam logic [7:0] AMPLITUDE_SETTING_MASK = 8'h8f;

    // --------------------------------------------------------------------
    // Values after reset and step sizes
    // --------------------------------------------------------------------
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [6:0] RAMP_STEPS_RESET = 7'h00;
    localparam logic [9:0] OFFSET_RESET = 10'h000;
    localparam logic [9:0] RAMP_STEP_SIZE = 10'h002;
    localparam logic [7:0] RAMP_CNT_RESET = 8'h00;

    typedef logic [3:0][7:0] byte_quad_type;

endpackage

// File: hdl/synth_freq_and_power_fail_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - Enabled supply-fail detect shuts synthesizer and amplifier.
// - Detection acts only while amplifier transmits.
// - Detection works in fixed or adaptive mode.
// - Supply drop clears run bit, stops transmission.
// - Detect enable and adaptive bits stay unchanged.
// - Adaptive failure moves oscillator to unregulated supply.
// - Selected amplitude register ampmod bit clear means DEVIATION_VALUE.
// - Four 18-bit channel words are held.
// - Shared top-bits register, high and low bytes.
// - Transmit command selects active channel word.
// - Channel word sets fractional frequency, LSB ref/32768.
// - 8-bit deviation gives ref*value/16384 offset.
// - Reference halving bit halves reference clock.
// - Band divider bit selects direct or halved.
// - Soft-DEVIATION_VALUE ramps linearly in steps between tones.
// - Ramp value zero gives plain tone switching.
// - Ramp time (2-band)*2*deviation*ramp reference clocks.
// - Adaptive bit selects regulator reference source.
module synth_freq_and_power_fail_ctrl
    import synth_ctrl_pkg::*;
(
    input wire logic core_clk_in, // Reference-derived core clock.
    input wire logic arst_n_in, // Asynchronous reset, active low.
    input wire logic [7:0] reg_addr_in, // Register address.
    input wire logic [7:0] reg_wdata_in, // Register write data.
    input wire logic reg_we_in, // Register write strobe.
    input wire logic tx_cmd_in, // Transmit command strobe.
    input wire logic [1:0] word_sel_in, // Channel word select.
    input wire logic amp_sel_in, // Amplitude register select.
    input wire logic tx_stop_in, // Transmission stop strobe.
    input wire logic tx_data_in, // Transmit data bit.
    input wire logic supply_fail_in, // Asynchronous brown-out flag.
    output logic [7:0] reg_rdata_out, // Read data, one cycle late.
    output logic synth_run_out, // Synthesizer running.
    output logic pa_enable_out, // Power amplifier enabled.
    output logic osc_regulated_out, // Oscillator on regulated supply.
    output logic regulator_adaptive_out, // Regulator adaptive mode.
    output logic ref_halve_out, // Reference clock halved.
    output logic band_div_direct_out, // Amplifier fed undivided.
    output logic fsk_mode_out, // DEVIATION_VALUE amplitude path selected.
    output logic [3:0] amp_level_out, // Selected high amplitude.
    output logic [17:0] channel_word_out, // Active channel word.
    output logic [9:0] dev_offset_out // Signed offset in word LSBs.
);

    // --------------------------------------------------------------------
    // State
    // --------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] freq_word_msbs;
        byte_quad_type freq_word_high;
        byte_quad_type freq_word_low;
        logic [7:0] deviation_setting;
        logic [6:0] ramp_steps;
        logic [7:0] transmitter_control;
        logic [7:0] amplitude_setting_0;
        logic [7:0] amplitude_setting_1;
        logic [7:0] amplitude_setting_2;
        logic tx_active;
        logic [1:0] word_sel;
        logic amp_sel;
        logic [17:0] channel_word;
        logic [9:0] offset;
        logic [7:0] ramp_cnt;
        logic ref_phase;
        logic fail_s1;
        logic fail_s2;
        logic [7:0] rdata;
        logic fsk_mode;
        logic [3:0] amp_level;
    } state_type;

    state_type st;
    state_type next_st;
    logic fail_evt;
    logic fsk_now;
    logic ref_tick;
    logic in_ramp;
    logic [7:0] sel_amp;
    logic [9:0] twice_dev;
    logic [9:0] target;
    logic [7:0] period;
    logic [17:0] cmd_word;
    logic [7:0] fc_rel;

    // Word n takes its top two bits from pair n of the shared register.
    function automatic logic [17:0] chan_word(input logic [7:0] msbs,
        input byte_quad_type hi, input byte_quad_type lo,
        input logic [1:0] sel);
        logic [17:0] w;
        w = {msbs[{sel, 1'b1}], msbs[{sel, 1'b0}], hi[sel], lo[sel]};
        return w;
    endfunction

    // Register read mux; reserved and unmapped bits read as zero.
    function automatic logic [7:0] read_of(input state_type s,
        input logic [7:0] addr);
        logic [7:0] r;
        logic [7:0] rel;
        r = 8'h00;
        rel = addr - FREQ_WORD_BASE_ADDR;
        if (addr == FREQ_WORD_MSBS_ADDR) begin
            r = s.freq_word_msbs;
        end else if (addr >= FREQ_WORD_BASE_ADDR &&
                     addr <= FREQ_WORD_LAST_ADDR) begin
            r = rel[0] ? s.freq_word_low[rel[2:1]]
                       : s.freq_word_high[rel[2:1]];
        end else if (addr == DEVIATION_SETTING_ADDR) begin
            r = s.deviation_setting;
        end else if (addr == AMPLITUDE_SETTING_0_ADDR) begin
            r = s.amplitude_setting_0;
        end else if (addr == AMPLITUDE_SETTING_1_ADDR) begin
            r = s.amplitude_setting_1;
        end else if (addr == AMPLITUDE_SETTING_2_ADDR) begin
            r = s.amplitude_setting_2;
        end else if (addr == RAMP_CONTROL_ADDR) begin
            r = {1'b0, s.ramp_steps};
        end else if (addr == TRANSMITTER_CONTROL_ADDR) begin
            r = s.transmitter_control;
        end
        return r;
    endfunction

    // --------------------------------------------------------------------
    // Decoded helpers
    // --------------------------------------------------------------------
    // The brown-out event ignores the regulator mode bit on purpose.
    assign fail_evt = st.amplitude_setting_2[SUPPLY_FAIL_DETECT_EN_BIT] &
                      st.tx_active & st.fail_s2;
    assign sel_amp = st.amp_sel ? st.amplitude_setting_1
                                : st.amplitude_setting_0;
    assign fsk_now = ~sel_amp[AMPMOD_ON_BIT];
    // A halved reference ticks on every second core edge.
    assign ref_tick = ~st.transmitter_control[REF_HALVE_SEL_BIT] |
                      st.ref_phase;
    // One deviation LSB is two channel-word LSBs (16384 versus 32768).
    assign twice_dev = {1'b0, st.deviation_setting, 1'b0};
    assign target = tx_data_in ? twice_dev : (10'h000 - twice_dev);
    // Ticks between steps; the halved band path doubles the dwell.
    assign period = st.transmitter_control[BAND_DIVIDER_SEL_BIT]
                    ? {1'b0, st.ramp_steps}
                    : {st.ramp_steps, 1'b0};
    assign in_ramp = st.tx_active & fsk_now & (st.ramp_steps != 7'h00);
    assign cmd_word = chan_word(st.freq_word_msbs, st.freq_word_high,
                                st.freq_word_low, word_sel_in);
    assign fc_rel = reg_addr_in - FREQ_WORD_BASE_ADDR;

    // --------------------------------------------------------------------
    // Next-state logic
    // --------------------------------------------------------------------
    always_comb begin
        next_st = st;
        // Only the second stage is read by any logic.
        next_st.fail_s1 = supply_fail_in;
        next_st.fail_s2 = st.fail_s1;
        next_st.ref_phase = st.transmitter_control[REF_HALVE_SEL_BIT]
                            ? ~st.ref_phase : 1'b0;
        next_st.rdata = read_of(st, reg_addr_in);

        // Register writes.
        if (reg_we_in) begin
            if (reg_addr_in == FREQ_WORD_MSBS_ADDR) begin
                next_st.freq_word_msbs = reg_wdata_in;
            end else if (reg_addr_in >= FREQ_WORD_BASE_ADDR &&
                         reg_addr_in <= FREQ_WORD_LAST_ADDR) begin
                if (fc_rel[0]) begin
                    next_st.freq_word_low[fc_rel[2:1]] =
                        reg_wdata_in;
                end else begin
                    next_st.freq_word_high[fc_rel[2:1]] =
                        reg_wdata_in;
                end
            end else if (reg_addr_in == DEVIATION_SETTING_ADDR) begin
                next_st.deviation_setting = reg_wdata_in;
            end else if (reg_addr_in == AMPLITUDE_SETTING_0_ADDR) begin
                next_st.amplitude_setting_0 =
                    reg_wdata_in & AMPLITUDE_SETTING_MASK;
            end else if (reg_addr_in == AMPLITUDE_SETTING_1_ADDR) begin
                next_st.amplitude_setting_1 =
                    reg_wdata_in & AMPLITUDE_SETTING_MASK;
            end else if (reg_addr_in == AMPLITUDE_SETTING_2_ADDR) begin
                next_st.amplitude_setting_2 = reg_wdata_in;
            end else if (reg_addr_in == RAMP_CONTROL_ADDR) begin
                next_st.ramp_steps = reg_wdata_in[6:0];
            end else if (reg_addr_in == TRANSMITTER_CONTROL_ADDR) begin
                next_st.transmitter_control = reg_wdata_in;
            end
        end

        // Transmit command picks word and amplitude without a write.
        if (tx_cmd_in && st.transmitter_control[SYNTH_RUN_BIT]) begin
            next_st.tx_active = 1'b1;
            next_st.word_sel = word_sel_in;
            next_st.amp_sel = amp_sel_in;
        end
        if (tx_stop_in || !next_st.transmitter_control[SYNTH_RUN_BIT]) begin
            next_st.tx_active = 1'b0;
        end

        // Brown-out beats a same-cycle software write to the run bit, and to the osc bit only if it was already set.
        // Detect enable and adaptive bits are deliberately left alone.
        if (fail_evt) begin
            next_st.transmitter_control[SYNTH_RUN_BIT] = 1'b0;
            next_st.tx_active = 1'b0;
            if (st.amplitude_setting_2[REGULATOR_ADAPTIVE_EN_BIT] &&
                st.transmitter_control[OSC_REGULATED_SUPPLY_BIT]) begin
                next_st.transmitter_control[OSC_REGULATED_SUPPLY_BIT] =
                    1'b0;
            end
        end

        // Frequency offset: immediate, or one step per ramp period.
        if (!st.tx_active || !fsk_now) begin
            next_st.offset = OFFSET_RESET;
            next_st.ramp_cnt = RAMP_CNT_RESET;
        end else if (st.ramp_steps == 7'h00) begin
            next_st.offset = target;
        end else if (ref_tick) begin
            if (st.ramp_cnt == 8'h00) begin
                if (st.offset != target) begin
                    if ($signed(st.offset) < $signed(target)) begin
                        next_st.offset = st.offset + RAMP_STEP_SIZE;
                    end else begin
                        next_st.offset = st.offset - RAMP_STEP_SIZE;
                    end
                    next_st.ramp_cnt = period - 8'h01;
                end
            end else begin
                next_st.ramp_cnt = st.ramp_cnt - 8'h01;
            end
        end

        // The synthesizer adds half an LSB itself; the word goes out raw.
        next_st.channel_word = chan_word(st.freq_word_msbs,
            st.freq_word_high, st.freq_word_low, next_st.word_sel);
        next_st.fsk_mode = fsk_now;
        next_st.amp_level = sel_amp[3:0];
    end

    // --------------------------------------------------------------------
    // State register
    // --------------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs are state fields, so each comes from a flip-flop.
    assign reg_rdata_out = st.rdata;
    assign synth_run_out = st.transmitter_control[SYNTH_RUN_BIT];
    assign pa_enable_out = st.tx_active;
    assign osc_regulated_out =
        st.transmitter_control[OSC_REGULATED_SUPPLY_BIT];
    assign regulator_adaptive_out =
        st.amplitude_setting_2[REGULATOR_ADAPTIVE_EN_BIT];
    assign ref_halve_out = st.transmitter_control[REF_HALVE_SEL_BIT];
    assign band_div_direct_out =
        st.transmitter_control[BAND_DIVIDER_SEL_BIT];
    assign fsk_mode_out = st.fsk_mode;
    assign amp_level_out = st.amp_level;
    assign channel_word_out = st.channel_word;
    assign dev_offset_out = st.offset;

    // --------------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------------
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    AST_FAIL_STOPS: assert property (fail_evt |=>
        !synth_run_out && !pa_enable_out)
        else $error("Brown-out did not stop synthesizer and amplifier.");
    AST_NO_DETECT_KEEPS: assert property (
        !st.amplitude_setting_2[SUPPLY_FAIL_DETECT_EN_BIT] && st.fail_s2 &&
        st.tx_active && !tx_stop_in && !reg_we_in |=> pa_enable_out)
        else $error("Disabled detection still stopped transmission.");
    AST_IDLE_IGNORES: assert property (
        st.fail_s2 && !st.tx_active && !reg_we_in |=>
        $stable(st.transmitter_control))
        else $error("Detection acted outside transmission.");
    AST_BITS_KEPT: assert property (fail_evt && !reg_we_in |=>
        $stable(st.amplitude_setting_2))
        else $error("Brown-out changed detect or adaptive bits.");
    AST_OSC_UNREG: assert property (fail_evt &&
        st.amplitude_setting_2[REGULATOR_ADAPTIVE_EN_BIT] |=>
        !osc_regulated_out)
        else $error("Oscillator stayed on regulated supply.");
    AST_OSC_FIXED: assert property (fail_evt && !reg_we_in &&
        !st.amplitude_setting_2[REGULATOR_ADAPTIVE_EN_BIT] |=>
        osc_regulated_out == $past(osc_regulated_out))
        else $error("Fixed mode brown-out touched oscillator supply.");
    AST_SYNC_DELAY: assert property ($rose(st.fail_s2) |->
        $past(supply_fail_in, 2))
        else $error("Supply-fail flag skipped its synchronizer.");
    AST_WORD_SEL: assert property (tx_cmd_in &&
        st.transmitter_control[SYNTH_RUN_BIT] |=>
        channel_word_out == $past(cmd_word))
        else $error("Transmit command did not select channel word.");
    AST_PLAIN_FSK: assert property (st.tx_active && fsk_now &&
        st.ramp_steps == 7'h00 && !tx_stop_in && !reg_we_in && !fail_evt
        |=> dev_offset_out == $past(target))
        else $error("Plain DEVIATION_VALUE did not jump to the tone.");
    AST_RAMP_STEP: assert property ($past(in_ramp) &&
        $changed(st.offset) |->
        (st.offset - $past(st.offset) == RAMP_STEP_SIZE ||
         $past(st.offset) - st.offset == RAMP_STEP_SIZE))
        else $error("Soft-DEVIATION_VALUE offset moved by other than one step.");

    COV_FAIL: cover property (fail_evt ##1 !pa_enable_out);
    COV_RAMP_UP: cover property (in_ramp && tx_data_in ##1
        $changed(st.offset));
    COV_CMD: cover property (tx_cmd_in && word_sel_in == 2'b11);

endmodule

// File: dv/tb_synth_freq_and_power_fail_ctrl.sv
`timescale 1ns/1ps
module tb_synth_freq_and_power_fail_ctrl;
    import synth_ctrl_pkg::*;

    // ------------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------------
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic we = 1'b0;
    logic cmd = 1'b0;
    logic [1:0] wsel = 2'h0;
    logic asel = 1'b0;
    logic stop = 1'b0;
    logic txd = 1'b0;
    logic fail = 1'b0;
    logic [7:0] rdata;
    logic run, pa, osc, adapt, halve, bdir, deviation_value;
    logic [3:0] lvl;
    logic [17:0] cw;
    logic [9:0] off;
    int n_mismatch = 0;
    int checked = 0;

    synth_freq_and_power_fail_ctrl synth_freq_and_power_fail_ctrl_inst (
        .core_clk_in(clk), .arst_n_in(arst_n), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_we_in(we), .tx_cmd_in(cmd),
        .word_sel_in(wsel), .amp_sel_in(asel), .tx_stop_in(stop),
        .tx_data_in(txd), .supply_fail_in(fail), .reg_rdata_out(rdata),
        .synth_run_out(run), .pa_enable_out(pa), .osc_regulated_out(osc),
        .regulator_adaptive_out(adapt), .ref_halve_out(halve),
        .band_div_direct_out(bdir), .fsk_mode_out(deviation_value),
        .amp_level_out(lvl), .channel_word_out(cw), .dev_offset_out(off));

    // The 50 MHz core clock.
    initial begin
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Shared tasks; every driver starts 1 ns after a rising edge.
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        we = 1'b1;
        cyc(1);
        // The strobe rests low for a full cycle so the next write starts clean.
        we = 1'b0;
        cyc(1);
    endtask

    // Address is held for two edges so the registered read has settled.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        cyc(2);
        chk("rdata", rdata, exp);
    endtask

    task automatic tx(input logic [1:0] s, input logic am);
        wsel = s;
        asel = am;
        cmd = 1'b1;
        cyc(1);
        cmd = 1'b0;
        cyc(1);
    endtask

    task automatic halt();
        stop = 1'b1;
        cyc(1);
        stop = 1'b0;
        chk("pa_stop", pa, 1'b0);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Reset values, unmapped space and read-only bits.
    task automatic t_regs();
        for (int a = 0; a < 16; a++) begin
            rd_chk(a[7:0], REG_RESET);
        end
        rd_chk(8'hff, 8'h00);
        wr(RAMP_CONTROL_ADDR, 8'hff);
        rd_chk(RAMP_CONTROL_ADDR, 8'h7f);
        wr(AMPLITUDE_SETTING_0_ADDR, 8'hff);
        rd_chk(AMPLITUDE_SETTING_0_ADDR, 8'h8f);
        wr(DEVIATION_SETTING_ADDR, 8'ha5);
        rd_chk(DEVIATION_SETTING_ADDR, 8'ha5);
        wr(RAMP_CONTROL_ADDR, 8'h00);
        wr(AMPLITUDE_SETTING_0_ADDR, 8'h00);
    endtask

    // All four channel words, one at the overflow limit, picked by command.
    task automatic t_words();
        logic [7:0] hi [4] = '{8'h12, 8'h34, 8'h7f, 8'h9a};
        logic [7:0] lo [4] = '{8'h56, 8'h78, 8'hff, 8'hbc};
        logic [7:0] msbs = 8'h64;
        wr(FREQ_WORD_MSBS_ADDR, msbs);
        for (int n = 0; n < 4; n++) begin
            wr(8'(1 + 2 * n), hi[n]);
            wr(8'(2 + 2 * n), lo[n]);
        end
        rd_chk(FREQ_WORD_LAST_ADDR, 8'hbc);
        tx(2'h1, 1'b0);
        chk("pa_norun", pa, 1'b0);
        wr(TRANSMITTER_CONTROL_ADDR, 8'h01);
        for (int n = 0; n < 4; n++) begin
            tx(n[1:0], 1'b0);
            chk("pa_on", pa, 1'b1);
            chk("word", cw, {msbs[2*n+:2], hi[n], lo[n]});
        end
        halt();
    endtask

    // Plain DEVIATION_VALUE tones and the amplitude register choice.
    task automatic t_fsk();
        wr(DEVIATION_SETTING_ADDR, 8'h0f);
        wr(AMPLITUDE_SETTING_0_ADDR, 8'h05);
        wr(AMPLITUDE_SETTING_1_ADDR, 8'h83);
        txd = 1'b1;
        tx(2'h0, 1'b0);
        cyc(1);
        chk("off_up", off, 10'h01e);
        chk("fsk0", deviation_value, 1'b1);
        chk("lvl0", lvl, 4'h5);
        txd = 1'b0;
        cyc(1);
        chk("off_dn", off, 10'h3e2);
        tx(2'h0, 1'b1);
        cyc(2);
        chk("fsk1", deviation_value, 1'b0);
        chk("lvl1", lvl, 4'h3);
        chk("off_ask", off, 10'h000);
        halt();
    endtask

    // Soft ramp: stepping, duration, band divider and reference halving.
    task automatic t_ramp();
        logic [7:0] cfg [3] = '{8'h11, 8'h01, 8'h31};
        int lo_n [3] = '{6, 12, 12};
        int hi_n [3] = '{9, 17, 18};
        int n;
        logic ok;
        logic [9:0] prev;
        wr(RAMP_CONTROL_ADDR, 8'h02);
        wr(DEVIATION_SETTING_ADDR, 8'h02);
        wr(AMPLITUDE_SETTING_0_ADDR, 8'h00);
        for (int i = 0; i < 3; i++) begin
            wr(TRANSMITTER_CONTROL_ADDR, cfg[i]);
            chk("halve", halve, cfg[i][5]);
            chk("bdir", bdir, cfg[i][4]);
            txd = 1'b1;
            tx(2'h0, 1'b0);
            n = 0;
            while (off !== 10'h004 && n < 100) begin
                cyc(1);
                n++;
            end
            txd = 1'b0;
            n = 0;
            ok = 1'b1;
            prev = off;
            while (off !== 10'h3fc && n < 200) begin
                cyc(1);
                n++;
                if ((prev - off) !== 10'h000 &&
                    (prev - off) !== 10'h002) begin
                    ok = 1'b0;
                end
                prev = off;
            end
            chk("linear", ok, 1'b1);
            chk("ramp_t", n >= lo_n[i] && n <= hi_n[i], 1'b1);
            halt();
        end
        wr(RAMP_CONTROL_ADDR, 8'h00);
    endtask

    // One brown-out case: config, optional transmission, expected result.
    task automatic bo(input logic [7:0] amp2, input logic do_tx,
                      input logic e_run, input logic e_osc, input logic e_pa);
        wr(AMPLITUDE_SETTING_2_ADDR, amp2);
        wr(TRANSMITTER_CONTROL_ADDR, 8'h03);
        if (do_tx) begin
            tx(2'h0, 1'b0);
        end
        fail = 1'b1;
        cyc(2);
        chk("pa_sync", pa, do_tx);
        cyc(1);
        chk("run_bo", run, e_run);
        chk("pa_bo", pa, e_pa);
        chk("osc_bo", osc, e_osc);
        chk("adapt", adapt, amp2[6]);
        rd_chk(AMPLITUDE_SETTING_2_ADDR, amp2);
        rd_chk(TRANSMITTER_CONTROL_ADDR, {6'h00, e_osc, e_run});
        fail = 1'b0;
        cyc(3);
        if (pa === 1'b1) begin
            halt();
        end
        wr(TRANSMITTER_CONTROL_ADDR, 8'h00);
    endtask

    task automatic t_fail();
        bo(8'h60, 1'b1, 1'b0, 1'b0, 1'b0);
        bo(8'h20, 1'b1, 1'b0, 1'b1, 1'b0);
        bo(8'h00, 1'b1, 1'b1, 1'b1, 1'b1);
        bo(8'h20, 1'b0, 1'b1, 1'b1, 1'b0);
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    // Reset is held across two edges, then released just after an edge.
    initial begin
        repeat (2) @(posedge clk);
        #1;
        arst_n = 1'b1;
        t_regs();
        t_words();
        t_fsk();
        t_ramp();
        t_fail();
        test_done();
    end

    // The scenarios need a few hundred cycles; this leaves wide margin.
    initial begin
        #500000;
        n_mismatch++;
        test_done();
    end
endmodule
